/* inc/psr_pkg.sv */
// Constants, timing counts and state types of the pixel strip renderer
package psr_pkg;

   // ****************************************
   // Clocks
   // ****************************************
   localparam int unsigned CLK_PERIOD_PS  = 5000;
   localparam int unsigned LINK_PERIOD_PS = 12000;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [15:0] TRIG_ADDR  = 16'h0000;
   localparam logic [15:0] CHAN_FIRST = 16'h0001;
   localparam logic [15:0] CHAN_LAST  = 16'h0e10;
   localparam logic [7:0]  TRIG_RESET = 8'h00;
   localparam logic [7:0]  TRIG_GO    = 8'h01;
   localparam logic [7:0]  READ_NONE  = 8'h00;

   // ****************************************
   // Pixel bit timing
   // ****************************************
   localparam int unsigned ZERO_HIGH_NS = 360;
   localparam int unsigned ZERO_LOW_NS  = 860;
   localparam int unsigned ONE_HIGH_NS  = 800;
   localparam int unsigned ONE_LOW_NS   = 430;
   localparam int unsigned LATCH_NS     = 338;
   localparam int unsigned ZERO_HIGH_CYC = (ZERO_HIGH_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
   localparam int unsigned ZERO_LOW_CYC  = (ZERO_LOW_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
   localparam int unsigned ONE_HIGH_CYC  = (ONE_HIGH_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
   localparam int unsigned ONE_LOW_CYC   = (ONE_LOW_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
   localparam int unsigned LATCH_CYC     = (LATCH_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;

   // ****************************************
   // Serial bus input filtering
   // ****************************************
   localparam logic [1:0]  SPD_STD       = 2'h0;
   localparam logic [1:0]  SPD_FAST      = 2'h1;
   localparam int unsigned FILT_STD_NS   = 250;
   localparam int unsigned FILT_FAST_NS  = 100;
   localparam int unsigned FILT_FPLUS_NS = 50;
   localparam int unsigned FILT_STD_CYC   = (FILT_STD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned FILT_FAST_CYC  = (FILT_FAST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned FILT_FPLUS_CYC = (FILT_FPLUS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

   // ****************************************
   // State types
   // ****************************************
   typedef enum logic [7:0] {
      SB_IDLE   = 8'h01,
      SB_DEVADR = 8'h02,
      SB_PTRHI  = 8'h04,
      SB_PTRLO  = 8'h08,
      SB_WDATA  = 8'h10,
      SB_ACK    = 8'h20,
      SB_RDATA  = 8'h40,
      SB_RACK   = 8'h80
   } psr_bus_st_t;

   typedef enum logic [2:0] {
      EN_IDLE = 3'h1,
      EN_SEND = 3'h2,
      EN_WAIT = 3'h4
   } psr_eng_st_t;

   typedef enum logic [3:0] {
      PX_IDLE  = 4'h1,
      PX_HIGH  = 4'h2,
      PX_LOW   = 4'h4,
      PX_LATCH = 4'h8
   } psr_pix_st_t;

endpackage : psr_pkg

/* inc/psr_byte_if.sv */
// Byte handover from the render engine to the pixel encoder
interface psr_byte_if;
   logic [7:0] data;
   logic       last;
   logic       req_tgl;
   logic       ack_tgl;

   modport src (
      output data,
      output last,
      output req_tgl,
      input  ack_tgl
   );
   modport snk (
      input  data,
      input  last,
      input  req_tgl,
      output ack_tgl
   );
endinterface : psr_byte_if

/* rtl/psr_glitch_filter.sv */
// Pin synchroniser with a spike filter of selectable length
module psr_glitch_filter
   import psr_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       raw,
   input  wire logic [5:0] limit,
   output logic            filt_q
);
   logic       s1_q;
   logic       s2_q;
   logic [5:0] cnt_q;

   always_ff @(posedge clk) begin
      s1_q <= raw;
      s2_q <= s1_q;
   end

   // Level must stay changed for limit + 1 cycles before it is accepted
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q  <= 6'h00;
         filt_q <= 1'b1;
      end else if (s2_q == filt_q) begin
         cnt_q <= 6'h00;
      end else if (cnt_q >= limit) begin
         cnt_q  <= 6'h00;
         filt_q <= s2_q;
      end else begin
         cnt_q <= cnt_q + 6'h01;
      end
   end
endmodule : psr_glitch_filter

/* rtl/psr_pixel_encoder.sv */
// Pulse-width bit coder on the link clock
module psr_pixel_encoder
   import psr_pkg::*;
(
   input  wire logic   pix_clk,
   input  wire logic   rst,
   psr_byte_if.snk     byte_in,
   output logic        pixel_out
);
   logic        rst_s1_q;
   logic        rst_s2_q;
   logic        req_s1_q;
   logic        req_s2_q;
   psr_pix_st_t st_q;
   psr_pix_st_t st_d;
   logic [7:0]  cnt_q;
   logic [7:0]  cnt_d;
   logic [2:0]  bit_q;
   logic [2:0]  bit_d;
   logic [7:0]  sh_q;
   logic [7:0]  sh_d;
   logic        last_q;
   logic        last_d;
   logic        ack_q;
   logic        ack_d;
   logic        out_q;
   logic        out_d;

   wire         have_byte = req_s2_q != ack_q;
   wire         cnt_done  = cnt_q == 8'h00;
   wire  [7:0]  data_high = byte_in.data[7] ? 8'(ONE_HIGH_CYC - 1) : 8'(ZERO_HIGH_CYC - 1);
   wire  [7:0]  next_high = sh_q[6] ? 8'(ONE_HIGH_CYC - 1) : 8'(ZERO_HIGH_CYC - 1);
   wire  [7:0]  cur_low   = sh_q[7] ? 8'(ONE_LOW_CYC - 1) : 8'(ZERO_LOW_CYC - 1);

   assign byte_in.ack_tgl = ack_q;
   assign pixel_out       = out_q;

   always_ff @(posedge pix_clk) begin
      rst_s1_q <= rst;
      rst_s2_q <= rst_s1_q;
      req_s1_q <= byte_in.req_tgl;
      req_s2_q <= req_s1_q;
   end

   always_comb begin
      st_d   = st_q;
      cnt_d  = cnt_q;
      bit_d  = bit_q;
      sh_d   = sh_q;
      last_d = last_q;
      ack_d  = ack_q;
      out_d  = out_q;
      case (st_q)
         PX_IDLE: begin
            out_d = 1'b0;                                    // see R18
            if (have_byte) begin
               sh_d   = byte_in.data;                        // see R10
               last_d = byte_in.last;
               ack_d  = req_s2_q;
               bit_d  = 3'h0;
               cnt_d  = data_high;
               out_d  = 1'b1;
               st_d   = PX_HIGH;
            end
         end
         PX_HIGH: begin
            if (cnt_done) begin
               cnt_d = cur_low;                              // see R11 see R12
               out_d = 1'b0;
               st_d  = PX_LOW;
            end else begin
               cnt_d = cnt_q - 8'h01;
            end
         end
         PX_LOW: begin
            if (!cnt_done) begin
               cnt_d = cnt_q - 8'h01;
            end else if (bit_q != 3'h7) begin
               bit_d = bit_q + 3'h1;
               sh_d  = {sh_q[6:0], 1'b0};                    // see R16
               cnt_d = next_high;                            // see R13
               out_d = 1'b1;
               st_d  = PX_HIGH;
            end else if (last_q) begin
               cnt_d = 8'(LATCH_CYC - 1);                    // see R14
               st_d  = PX_LATCH;
            end else if (have_byte) begin
               sh_d   = byte_in.data;
               last_d = byte_in.last;
               ack_d  = req_s2_q;
               bit_d  = 3'h0;
               cnt_d  = data_high;
               out_d  = 1'b1;
               st_d   = PX_HIGH;
            end else begin
               st_d = PX_IDLE;
            end
         end
         PX_LATCH: begin
            out_d = 1'b0;                                    // see R14 see R18
            if (cnt_done) begin
               st_d = PX_IDLE;
            end else begin
               cnt_d = cnt_q - 8'h01;
            end
         end
         default: begin
            st_d  = PX_IDLE;
            out_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge pix_clk) begin
      if (rst_s2_q) begin
         st_q   <= PX_IDLE;
         cnt_q  <= 8'h00;
         bit_q  <= 3'h0;
         sh_q   <= 8'h00;
         last_q <= 1'b0;
         ack_q  <= 1'b0;
         out_q  <= 1'b0;
      end else begin
         st_q   <= st_d;
         cnt_q  <= cnt_d;
         bit_q  <= bit_d;
         sh_q   <= sh_d;
         last_q <= last_d;
         ack_q  <= ack_d;
         out_q  <= out_d;
      end
   end
endmodule : psr_pixel_encoder

/* rtl/psr_top.sv */
// Serial-bus slave, byte store and render engine of the pixel strip renderer
//
// Operation
// R1: Answers as a two-wire bus slave for reading and writing the byte map.
// R2: Input filter length follows bus_speed_select; master runs at that speed.
// R3: One flat page of 3601 byte registers, addresses 0 to 3600.
// R4: Single and block reads and writes, like a serial memory.
// R5: Address 0 is render_trigger; 1 to 3600 are channel_byte registers.
// R6: Writing 1 to render_trigger sends all channel bytes on pixel_out.
// R7: render_trigger clears itself to 0 once the frame has started.
// R8: Channel writes reach pixel_out only on the next trigger; a write during a frame to a byte not yet sent goes out in that frame.
// R9: Bytes go out in ascending order, address 1 through 3600.
// R10: Bytes are sent unchanged; only the bit coding is applied.
// R11: Zero bit: high 360-380 ns, then low 860-880 ns.
// R12: One bit: high 800-820 ns, then low 430-450 ns.
// R13: Each bit period is nominally 1.25 us.
// R14: After a frame pixel_out stays low for the latch time of 338 ns.
// R15: Board ties bus_speed_select low, middle or high for the three speeds.
// R16: Each byte is sent most significant bit first.
// R17: Two address bytes load the pointer; it increments after every byte.
// R18: pixel_out idles low outside frames and during the latch interval.
module psr_top
   import psr_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h2a
)(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       pix_clk,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe,
   input  wire logic [1:0] bus_speed_select,
   output logic            pixel_out
);
   // ****************************************
   // Bus input conditioning
   // ****************************************
   logic       spd_s1_q;
   logic       spd_s2_q;
   logic       spd_s1b_q;
   logic       spd_s2b_q;
   logic       scl_f;
   logic       sda_f;
   logic       scl_p_q;
   logic       sda_p_q;
   logic [1:0] spd;
   logic [5:0] filt_limit;

   always_ff @(posedge clk) begin
      spd_s1_q  <= bus_speed_select[0];
      spd_s2_q  <= spd_s1_q;
      spd_s1b_q <= bus_speed_select[1];
      spd_s2b_q <= spd_s1b_q;
   end

   assign spd        = {spd_s2b_q, spd_s2_q};
   assign filt_limit = (spd == SPD_STD)  ? 6'(FILT_STD_CYC)  :     // see R2
                       (spd == SPD_FAST) ? 6'(FILT_FAST_CYC) :     // see R15
                                           6'(FILT_FPLUS_CYC);

   psr_glitch_filter u_scl_filt (
      .clk    (clk),
      .rst    (rst),
      .raw    (scl_i),
      .limit  (filt_limit),
      .filt_q (scl_f)
   );

   psr_glitch_filter u_sda_filt (
      .clk    (clk),
      .rst    (rst),
      .raw    (sda_i),
      .limit  (filt_limit),
      .filt_q (sda_f)
   );

   always_ff @(posedge clk) begin
      if (rst) begin
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else begin
         scl_p_q <= scl_f;
         sda_p_q <= sda_f;
      end
   end

   wire scl_rise = scl_f & ~scl_p_q;
   wire scl_fall = ~scl_f & scl_p_q;
   wire bus_start = scl_f & scl_p_q & sda_p_q & ~sda_f;
   wire bus_stop  = scl_f & scl_p_q & ~sda_p_q & sda_f;

   // ****************************************
   // Bus slave state machine
   // ****************************************
   psr_bus_st_t st_q;
   psr_bus_st_t st_d;
   psr_bus_st_t nxt_q;
   psr_bus_st_t nxt_d;
   logic [7:0]  sh_q;
   logic [7:0]  sh_d;
   logic [3:0]  bcnt_q;
   logic [3:0]  bcnt_d;
   logic [15:0] ptr_q;
   logic [15:0] ptr_d;
   logic        oe_q;
   logic        oe_d;
   logic        wr_en;
   logic [7:0]  rdata;

   wire byte_done = scl_fall & (bcnt_q == 4'h8);
   wire in_range  = ptr_q <= CHAN_LAST;                            // see R3

   assign sda_o  = 1'b0;
   assign sda_oe = oe_q;
   assign wr_en  = byte_done & (st_q == SB_WDATA) & in_range;

   always_comb begin
      st_d   = st_q;
      nxt_d  = nxt_q;
      sh_d   = sh_q;
      bcnt_d = bcnt_q;
      ptr_d  = ptr_q;
      oe_d   = oe_q;
      if (bus_start) begin
         st_d   = SB_DEVADR;                                       // see R1
         bcnt_d = 4'h0;
         oe_d   = 1'b0;
      end else if (bus_stop) begin
         st_d = SB_IDLE;
         oe_d = 1'b0;
      end else begin
         case (st_q)
            SB_DEVADR, SB_PTRHI, SB_PTRLO, SB_WDATA: begin
               if (scl_rise) begin
                  sh_d   = {sh_q[6:0], sda_f};
                  bcnt_d = bcnt_q + 4'h1;
               end else if (byte_done) begin
                  oe_d = 1'b1;
                  st_d = SB_ACK;
                  if (st_q == SB_DEVADR) begin
                     if (sh_q[7:1] != DEV_ADDR) begin
                        oe_d = 1'b0;
                        st_d = SB_IDLE;
                     end
                     nxt_d = sh_q[0] ? SB_RDATA : SB_PTRHI;
                  end else if (st_q == SB_PTRHI) begin
                     ptr_d[15:8] = sh_q;                           // see R17
                     nxt_d       = SB_PTRLO;
                  end else if (st_q == SB_PTRLO) begin
                     ptr_d[7:0] = sh_q;                            // see R17
                     nxt_d      = SB_WDATA;
                  end else begin
                     ptr_d = ptr_q + 16'h0001;                     // see R4 see R17
                     nxt_d = SB_WDATA;
                  end
               end
            end
            SB_ACK: begin
               if (scl_fall) begin
                  bcnt_d = 4'h0;
                  st_d   = nxt_q;
                  oe_d   = 1'b0;
                  if (nxt_q == SB_RDATA) begin
                     sh_d  = rdata;
                     oe_d  = ~rdata[7];
                     ptr_d = ptr_q + 16'h0001;                     // see R17
                  end
               end
            end
            SB_RDATA: begin
               if (scl_rise) begin
                  bcnt_d = bcnt_q + 4'h1;
               end else if (byte_done) begin
                  oe_d = 1'b0;
                  st_d = SB_RACK;
               end else if (scl_fall) begin
                  sh_d = {sh_q[6:0], 1'b0};
                  oe_d = ~sh_q[6];
               end
            end
            SB_RACK: begin
               if (scl_rise && sda_f) begin
                  st_d = SB_IDLE;
               end else if (scl_fall) begin
                  bcnt_d = 4'h0;
                  sh_d   = rdata;                                  // see R4
                  oe_d   = ~rdata[7];
                  ptr_d  = ptr_q + 16'h0001;
                  st_d   = SB_RDATA;
               end
            end
            default: begin
               oe_d = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_q   <= SB_IDLE;
         nxt_q  <= SB_IDLE;
         sh_q   <= 8'h00;
         bcnt_q <= 4'h0;
         ptr_q  <= 16'h0000;
         oe_q   <= 1'b0;
      end else begin
         st_q   <= st_d;
         nxt_q  <= nxt_d;
         sh_q   <= sh_d;
         bcnt_q <= bcnt_d;
         ptr_q  <= ptr_d;
         oe_q   <= oe_d;
      end
   end

   // ****************************************
   // Register store
   // ****************************************
   logic [7:0]  trig_q;
   logic [7:0]  chan_q [1:3600];
   logic        eng_start;

   wire trig_wr = wr_en & (ptr_q == TRIG_ADDR);                    // see R5
   wire chan_wr = wr_en & (ptr_q >= CHAN_FIRST);

   assign rdata = !in_range ? READ_NONE :
                  (ptr_q == TRIG_ADDR) ? trig_q : chan_q[ptr_q[11:0]];

   // A host write in the start cycle wins over the self-clear
   always_ff @(posedge clk) begin
      if (rst) begin
         trig_q <= TRIG_RESET;
      end else if (trig_wr) begin
         trig_q <= sh_q;
      end else if (eng_start) begin
         trig_q <= TRIG_RESET;                                     // see R7
      end
   end

   // Channel storage is volatile and left uninitialised by reset
   always_ff @(posedge clk) begin
      if (chan_wr) begin
         chan_q[ptr_q[11:0]] <= sh_q;                              // see R8
      end
   end

   // ****************************************
   // Render engine
   // ****************************************
   psr_eng_st_t eng_q;
   logic [11:0] idx_q;
   logic [7:0]  data_q;
   logic        last_q;
   logic        req_q;
   logic        ack_s1_q;
   logic        ack_s2_q;

   psr_byte_if  byte_link ();

   assign eng_start         = (eng_q == EN_IDLE) & (trig_q == TRIG_GO); // see R6
   assign byte_link.data    = data_q;
   assign byte_link.last    = last_q;
   assign byte_link.req_tgl = req_q;

   always_ff @(posedge clk) begin
      ack_s1_q <= byte_link.ack_tgl;
      ack_s2_q <= ack_s1_q;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         eng_q  <= EN_IDLE;
         idx_q  <= 12'h000;
         data_q <= 8'h00;
         last_q <= 1'b0;
         req_q  <= 1'b0;
      end else begin
         case (eng_q)
            EN_IDLE: begin
               if (eng_start) begin
                  idx_q <= CHAN_FIRST[11:0];                       // see R9
                  eng_q <= EN_SEND;
               end
            end
            EN_SEND: begin
               data_q <= chan_q[idx_q];                            // see R10
               last_q <= idx_q == CHAN_LAST[11:0];
               req_q  <= ~req_q;
               eng_q  <= EN_WAIT;
            end
            EN_WAIT: begin
               if (ack_s2_q == req_q) begin
                  idx_q <= idx_q + 12'h001;                        // see R9
                  eng_q <= last_q ? EN_IDLE : EN_SEND;
               end
            end
            default: begin
               eng_q <= EN_IDLE;
            end
         endcase
      end
   end

   psr_pixel_encoder u_enc (
      .pix_clk   (pix_clk),
      .rst       (rst),
      .byte_in   (byte_link),
      .pixel_out (pixel_out)
   );
endmodule : psr_top

/* test/psr_monitor.sv */
// Port checker of the pixel strip renderer, bound into psr_top
module psr_monitor
   import psr_pkg::*;
(
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       pix_clk,
   input wire logic       scl_i,
   input wire logic       sda_i,
   input wire logic       sda_o,
   input wire logic       sda_oe,
   input wire logic [1:0] bus_speed_select,
   input wire logic       pixel_out
);
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************
   // Pulse length counters on the link clock
   // ****************************************
   logic [11:0] hi_q;
   logic [11:0] lo_q;
   logic [11:0] prev_hi_q;
   logic        pix_q;
   logic [2:0]  prst_q;

   // Link-side reset lasts until the coder's synchronised reset has landed
   wire         prst = rst | prst_q[2];

   always_ff @(posedge pix_clk) begin
      prst_q    <= {prst_q[1:0], rst};
      pix_q     <= prst ? 1'b0 : pixel_out;
      hi_q      <= prst ? 12'h000 : (!pixel_out ? hi_q : (pix_q ? hi_q + 12'h001 : 12'h001));
      lo_q      <= prst ? 12'h000 : (pixel_out ? lo_q :
                   (!pix_q ? lo_q + {11'h000, ~&lo_q} : 12'h001));
      prev_hi_q <= prst ? 12'h000 : ((pix_q && !pixel_out) ? hi_q : prev_hi_q);
   end

   // ****************************************
   // Assertions
   // ****************************************
   sda_low_only_a: assert property (@(posedge clk) disable iff (rst) sda_o == 1'b0)
      else $error("data pin driven high");
   oe_after_reset_a: assert property (@(posedge clk) disable iff (rst)
      $fell(rst) |-> !sda_oe) else $error("data pin pulled right after reset");
   oe_scl_high_a: assert property (@(posedge clk) disable iff (rst)
      scl_i && $past(scl_i) |-> $stable(sda_oe)) else $error("data changed while clock high");
   ack_scl_low_a: assert property (@(posedge clk) disable iff (rst)
      $rose(sda_oe) |-> !scl_i) else $error("data pulled while clock high");
   ack_hold_a: assert property (@(posedge clk) disable iff (rst)
      $rose(sda_oe) |=> sda_oe [*8]) else $error("data pull too short");
   high_len_a: assert property (@(posedge pix_clk) disable iff (prst)
      $fell(pixel_out) |-> hi_q == 12'h01e || hi_q == 12'h043) else $error("bad high width");
   zero_low_a: assert property (@(posedge pix_clk) disable iff (prst)
      $rose(pixel_out) && prev_hi_q == 12'h01e |-> lo_q == 12'h048 || lo_q >= 12'h065)
      else $error("bad low width after zero bit");
   one_low_a: assert property (@(posedge pix_clk) disable iff (prst)
      $rose(pixel_out) && prev_hi_q == 12'h043 |-> lo_q == 12'h024 || lo_q >= 12'h041)
      else $error("bad low width after one bit");
   idle_low_a: assert property (@(posedge pix_clk) disable iff (prst) hi_q <= 12'h043)
      else $error("pixel line held high");
endmodule : psr_monitor

bind psr_top psr_monitor u_mon (
   .clk(clk), .rst(rst), .pix_clk(pix_clk), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
   .sda_oe(sda_oe), .bus_speed_select(bus_speed_select), .pixel_out(pixel_out)
);

/* test/psr_led_model.sv */
// Behavioural strip of pixels that decodes the pulse-width stream
module psr_led_model (
   input  wire logic   pix_clk,
   input  wire logic   rst,
   input  wire logic   pixel_out,
   output int          n_bits,
   output logic [31:0] shreg,
   output int          bad
);
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************
   // Decoder, sampling away from the launching edge
   // ****************************************
   int   hi;
   int   lo;
   logic prev;
   logic last_one;

   always @(negedge pix_clk) begin
      if (rst) begin
         n_bits = 0;
         bad = 0;
         hi = 0;
         lo = 0;
         prev = 1'b0;
         last_one = 1'b0;
         shreg = 32'h00000000;
      end else if (pixel_out === 1'b1) begin
         if (!prev && n_bits > 0) begin
            if (last_one ? !(lo inside {[36:37]} || lo >= 65)
                         : !(lo inside {[72:73]} || lo >= 101))
               bad++;
         end
         hi = prev ? hi + 1 : 1;
         prev = 1'b1;
      end else begin
         if (prev) begin
            last_one = (hi >= 50);
            if (!(hi inside {[30:31]} || hi inside {[67:68]}))
               bad++;
            if (n_bits < 32)
               shreg = {shreg[30:0], last_one};
            n_bits++;
            lo = 0;
         end
         lo++;
         prev = 1'b0;
      end
   end
endmodule : psr_led_model

/* test/i2c_pixel_strip_renderer_test.sv */
// Self-checking bench of the pixel strip renderer
module i2c_pixel_strip_renderer_test
   import psr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [6:0] DEV = 7'h2a;
   logic        clk, pix_clk, rst, scl_h, sda_h, sda_line, sda_o, sda_oe, pixel_out, ack;
   logic [1:0]  spd;
   logic [31:0] rnd = 32'h0000004d;
   logic [31:0] eb;
   logic [31:0] shreg;
   logic [7:0]  wbuf [0:8];
   logic [7:0]  rbuf [0:8];
   int          q = 50;
   int          n_fail = 0;
   int          checks = 0;
   int          n_bits, bad;

   assign sda_line = sda_h & ~sda_oe;

   psr_top #(.DEV_ADDR(DEV)) uut (.clk(clk), .rst(rst), .pix_clk(pix_clk), .scl_i(scl_h),
      .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .bus_speed_select(spd),
      .pixel_out(pixel_out));
   psr_led_model u_led (.pix_clk(pix_clk), .rst(rst), .pixel_out(pixel_out),
      .n_bits(n_bits), .shreg(shreg), .bad(bad));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      pix_clk = 1'b0;
      #1.7;
      forever #6 pix_clk = ~pix_clk;
   end

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction : xs

   // Address order, each byte most significant bit first
   function automatic logic [31:0] exp_bits(input logic [7:0] a, c, d, e);
      return {a, c, d, e};
   endfunction : exp_bits

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wq;
      repeat (q) @(negedge clk);
   endtask : wq

   task automatic start_c;
      sda_h = 1'b1;
      wq;
      scl_h = 1'b1;
      wq;
      sda_h = 1'b0;
      wq;
      scl_h = 1'b0;
      wq;
   endtask : start_c

   task automatic stop_c;
      sda_h = 1'b0;
      wq;
      scl_h = 1'b1;
      wq;
      sda_h = 1'b1;
      wq;
   endtask : stop_c

   task automatic clk_bit(input logic d, output logic s);
      sda_h = d;
      wq;
      scl_h = 1'b1;
      wq;
      s = sda_line;
      wq;
      scl_h = 1'b0;
      wq;
   endtask : clk_bit

   task automatic wr_byte(input logic [7:0] v);
      logic s;
      for (int i = 7; i >= 0; i--)
         clk_bit(v[i], s);
      clk_bit(1'b1, s);
      ack = ~s;
   endtask : wr_byte

   task automatic rd_byte(input logic nk, output logic [7:0] v);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(1'b1, s);
         v[i] = s;
      end
      clk_bit(nk, s);
   endtask : rd_byte

   task automatic addr_ptr(input logic [15:0] a);
      start_c;
      wr_byte({DEV, 1'b0});
      chk("address ack", 32'h1, ack);
      wr_byte(a[15:8]);
      wr_byte(a[7:0]);
      chk("pointer ack", 32'h1, ack);
   endtask : addr_ptr

   task automatic wr_block(input logic [15:0] a, input int n);
      addr_ptr(a);
      for (int i = 0; i < n; i++) begin
         wr_byte(wbuf[i]);
         chk("data ack", 32'h1, ack);
      end
      stop_c;
   endtask : wr_block

   task automatic rd_block(input logic [15:0] a, input int n);
      addr_ptr(a);
      start_c;
      wr_byte({DEV, 1'b1});
      chk("read address ack", 32'h1, ack);
      for (int i = 0; i < n; i++)
         rd_byte(i == n - 1, rbuf[i]);
      stop_c;
   endtask : rd_block

   task automatic report_and_stop;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : report_and_stop

   initial begin
      repeat (125000) @(posedge clk);
      n_fail++;
      $display("mismatch watchdog expected done seen timeout");
      report_and_stop;
   end

   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      rst = 1'b1;
      scl_h = 1'b1;
      sda_h = 1'b1;
      spd = 2'h2;
      repeat (6) @(negedge clk);
      rst = 1'b0;
      chk("sda_oe idle", 32'h0, sda_oe);
      repeat (60) @(negedge clk);
      chk("pixel_out idle", 32'h0, pixel_out);
      start_c;
      wr_byte({DEV ^ 7'h01, 1'b0});
      stop_c;
      chk("foreign address ack", 32'h0, ack);
      wbuf[0] = 8'h02;
      for (int i = 1; i < 9; i++) begin
         rnd = xs(rnd);
         wbuf[i] = rnd[7:0];
      end
      wbuf[1] = 8'h80;
      eb = exp_bits(wbuf[1], wbuf[2], wbuf[3], wbuf[4]);
      wr_block(TRIG_ADDR, 9);
      rd_block(TRIG_ADDR, 9);
      for (int i = 0; i < 9; i++)
         chk("register readback", {24'h0, wbuf[i]}, {24'h0, rbuf[i]});
      wbuf[0] = rnd[15:8];
      wbuf[1] = rnd[23:16];
      wr_block(CHAN_LAST, 2);
      rd_block(CHAN_LAST, 2);
      chk("last channel", {24'h0, wbuf[0]}, {24'h0, rbuf[0]});
      chk("beyond map", {24'h0, READ_NONE}, {24'h0, rbuf[1]});
      for (int s = 0; s < 2; s++) begin
         spd = s[1:0];
         q = (s == 0) ? 500 : 125;
         repeat (60) @(negedge clk);
         start_c;
         wr_byte({DEV, 1'b0});
         stop_c;
         chk("speed mode ack", 32'h1, ack);
      end
      spd = 2'h3;
      q = 50;
      repeat (60) @(negedge clk);
      chk("bits before trigger", 32'h0, n_bits);
      wbuf[0] = TRIG_GO;
      wr_block(TRIG_ADDR, 1);
      rd_block(TRIG_ADDR, 1);
      chk("trigger self clear", {24'h0, TRIG_RESET}, {24'h0, rbuf[0]});
      for (int k = 0; k < 20000 && n_bits < 32; k++)
         @(negedge clk);
      chk("first bytes on wire", eb, shreg);
      chk("pulse widths", 32'h0, bad);
      report_and_stop;
   end
endmodule : i2c_pixel_strip_renderer_test
